//--- shl_pkg.sv
package shl_pkg;
  localparam int REF_CLK_HZ = 11059200;
  localparam int REF_BAUD = 9600;
  localparam logic [10:0] BIT_CYCLES = 11'(REF_CLK_HZ / REF_BAUD - 1);
  localparam logic [10:0] HALF_CYCLES = 11'(REF_CLK_HZ / REF_BAUD / 2 - 1);
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_BANG = 8'h21;
  localparam logic [7:0] CH_Z = 8'h5A;
  localparam logic [7:0] ACK = 8'h06;
  localparam logic [7:0] NACK = 8'h15;
  localparam logic [7:0] PKT_ID0 = 8'h07;
  localparam logic [7:0] PKT_ID1 = 8'h0E;
  localparam logic [7:0] CMD_RUN = 8'h55;
  localparam logic [7:0] CMD_WRITE = 8'h57;
  localparam logic [7:0] CMD_ERASE = 8'h45;
  localparam logic [7:0] ERASE_ALL = 8'h41;
  localparam logic [7:0] ERASE_CODE = 8'h43;
  localparam logic [7:0] REC_DATA = 8'h00;
  localparam logic [7:0] REC_EOF = 8'h01;
  localparam logic [7:0] MAX_REC = 8'h10;
  localparam logic [7:0] MAX_PKT = 8'h19;
  localparam logic [4:0] OLD_ID_LEN = 5'h0B;
  localparam logic [4:0] NEW_ID_LEN = 5'h19;
  localparam int FIFO_DEPTH = 16;
  // identification strings: arbitrary neutral values
  localparam logic [87:0] OLD_ID = 88'h4C_44_52_30_30_30_31_20_61_62_63;
  localparam logic [191:0] NEW_ID =
    192'h58_59_5A_4C_44_52_20_56_32_2E_30_30_20_20_20_20_20_20_20_20_20_20_20_20;
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
  } shl_mem_wr_type;
  typedef struct packed {
    logic go;
    logic [15:0] addr;
  } shl_run_type;
  typedef enum logic [2:0] {SRC_ACK, SRC_NACK, SRC_OLD_ID, SRC_NEW_ID} shl_src_type;
  typedef enum logic [3:0] {
    ST_ENTRY, ST_HUNT, ST_HEX, ST_RUNHEX, ST_NEWRST, ST_PKT1, ST_PKT, ST_PROG, ST_SEND
  } shl_state_type;
endpackage : shl_pkg

//--- shl_loader.sv
`timescale 1ns/1ns
// ----------------------------------------
// receive byte fifo
// ----------------------------------------
module shl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready_o = (count != (AW + 1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : shl_fifo

// ----------------------------------------
// serial loader
// ----------------------------------------
module shl_loader #(
  parameter logic [10:0] BIT_CYCLES = shl_pkg::BIT_CYCLES,
  parameter logic [10:0] HALF_CYCLES = shl_pkg::HALF_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic new_gen_i,
  input wire logic uart_rx_i,
  output logic uart_tx_o,
  output shl_pkg::shl_mem_wr_type mem_wr_o,
  output logic erase_code_o,
  output logic erase_data_o,
  output shl_pkg::shl_run_type run_o,
  output logic overrun_o
);
  logic rx_s1, rx_s2, gen_s1, gen_s2, gen_new, gen_done;
  logic rx_busy, rx_valid, tx_busy, tx_go;
  logic [10:0] rx_cnt, tx_cnt;
  logic [3:0] rx_bit, tx_bit;
  logic [7:0] rx_sh, tx_byte;
  logic [9:0] tx_sh;
  logic f_ready, f_valid, take, pop;
  logic [7:0] f_data;
  shl_pkg::shl_state_type state;
  shl_pkg::shl_src_type src;
  logic [7:0] buf_mem [32];
  logic [7:0] len, idx, sum, bidx, pidx, pend, rec_type, hold, tx_sum;
  logic [15:0] addr;
  logic nib;
  logic [4:0] sidx, slen;
  logic [4:0] hv;
  logic [7:0] full_byte;

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      hex_val = {1'b1, 4'(c - 8'h30)};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      hex_val = {1'b1, 4'(c - 8'h37)};
    end else if (c >= 8'h61 && c <= 8'h66) begin
      hex_val = {1'b1, 4'(c - 8'h57)};
    end else begin
      hex_val = 5'h00;
    end
  endfunction : hex_val

  // ----------------------------------------
  // pin synchronisers and generation strap
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    rx_s1 <= uart_rx_i;
    rx_s2 <= rx_s1;
    gen_s1 <= new_gen_i;
    gen_s2 <= gen_s1;
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      gen_new <= 1'b0;
      gen_done <= 1'b0;
    end else if (!gen_done) begin
      gen_new <= gen_s2;
      gen_done <= 1'b1;
    end
  end

  // ----------------------------------------
  // uart receiver
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rx_busy <= 1'b0;
      rx_cnt <= 11'h000;
      rx_bit <= 4'h0;
      rx_sh <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_busy) begin
        if (!rx_s2) begin
          rx_busy <= 1'b1;
          rx_cnt <= HALF_CYCLES;
          rx_bit <= 4'h0;
        end
      end else if (rx_cnt != 11'h000) begin
        rx_cnt <= rx_cnt - 11'h001;
      end else begin
        rx_cnt <= BIT_CYCLES;
        if (rx_bit == 4'h0) begin
          rx_busy <= !rx_s2;
          rx_bit <= 4'h1;
        end else if (rx_bit <= 4'h8) begin
          rx_sh <= {rx_s2, rx_sh[7:1]};
          rx_bit <= rx_bit + 4'h1;
        end else begin
          rx_busy <= 1'b0;
          rx_valid <= rx_s2;
        end
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      overrun_o <= 1'b0;
    end else if (rx_valid && !f_ready) begin
      overrun_o <= 1'b1;
    end
  end

  shl_fifo #(.WIDTH(8), .DEPTH(shl_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_valid_i(rx_valid),
    .in_ready_o(f_ready),
    .in_data_i(rx_sh),
    .out_valid_o(f_valid),
    .out_ready_i(take),
    .out_data_o(f_data)
  );

  // ----------------------------------------
  // uart transmitter
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_busy <= 1'b0;
      tx_cnt <= 11'h000;
      tx_bit <= 4'h0;
      tx_sh <= 10'h3FF;
      uart_tx_o <= 1'b1;
    end else if (tx_go && !tx_busy) begin
      tx_busy <= 1'b1;
      tx_sh <= {1'b1, tx_byte, 1'b0};
      tx_cnt <= 11'h000;
      tx_bit <= 4'h0;
    end else if (tx_busy) begin
      if (tx_cnt != 11'h000) begin
        tx_cnt <= tx_cnt - 11'h001;
      end else if (tx_bit == 4'hA) begin
        tx_busy <= 1'b0;
      end else begin
        uart_tx_o <= tx_sh[0];
        tx_sh <= {1'b1, tx_sh[9:1]};
        tx_bit <= tx_bit + 4'h1;
        tx_cnt <= BIT_CYCLES;
      end
    end
  end

  // ----------------------------------------
  // command interpreter
  // ----------------------------------------
  assign take = (state inside {shl_pkg::ST_HUNT, shl_pkg::ST_HEX, shl_pkg::ST_RUNHEX,
                               shl_pkg::ST_NEWRST, shl_pkg::ST_PKT1, shl_pkg::ST_PKT});
  assign pop = take && f_valid;
  assign hv = hex_val(f_data);
  assign full_byte = {hold[3:0], hv[3:0]};

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state <= shl_pkg::ST_ENTRY;
      src <= shl_pkg::SRC_ACK;
      len <= 8'h00;
      idx <= 8'h00;
      sum <= 8'h00;
      bidx <= 8'h00;
      pidx <= 8'h00;
      pend <= 8'h00;
      rec_type <= 8'h00;
      hold <= 8'h00;
      nib <= 1'b0;
      addr <= 16'h0000;
      sidx <= 5'h00;
      slen <= 5'h00;
      tx_go <= 1'b0;
      tx_byte <= 8'h00;
      tx_sum <= 8'h00;
      mem_wr_o <= '0;
      run_o <= '0;
      erase_code_o <= 1'b0;
      erase_data_o <= 1'b0;
    end else begin
      tx_go <= 1'b0;
      mem_wr_o.we <= 1'b0;
      run_o.go <= 1'b0;
      erase_code_o <= 1'b0;
      erase_data_o <= 1'b0;
      case (state)
        shl_pkg::ST_ENTRY: begin
          if (gen_done) begin
            if (!gen_new) begin
              erase_code_o <= 1'b1;
              erase_data_o <= 1'b1;
              src <= shl_pkg::SRC_OLD_ID;
              slen <= shl_pkg::OLD_ID_LEN;
              sidx <= 5'h00;
              state <= shl_pkg::ST_SEND;
            end else begin
              state <= shl_pkg::ST_HUNT;
            end
          end
        end
        shl_pkg::ST_HUNT: begin
          if (pop) begin
            idx <= 8'h00;
            sum <= 8'h00;
            bidx <= 8'h00;
            nib <= 1'b0;
            sidx <= 5'h00;
            if (f_data == shl_pkg::CH_BANG && !gen_new) begin
              src <= shl_pkg::SRC_OLD_ID;
              slen <= shl_pkg::OLD_ID_LEN;
              state <= shl_pkg::ST_SEND;
            end else if (f_data == shl_pkg::CH_BANG) begin
              state <= shl_pkg::ST_NEWRST;
            end else if (f_data == shl_pkg::CH_COLON && !gen_new) begin
              state <= shl_pkg::ST_HEX;
            end else if (f_data == shl_pkg::CH_SEMI && !gen_new) begin
              state <= shl_pkg::ST_RUNHEX;
            end else if (f_data == shl_pkg::PKT_ID0 && gen_new) begin
              state <= shl_pkg::ST_PKT1;
            end
          end
        end
        shl_pkg::ST_HEX: begin
          if (pop) begin
            nib <= !nib;
            hold <= {4'h0, hv[3:0]};
            if (!hv[4]) begin
              src <= shl_pkg::SRC_NACK;
              slen <= 5'h01;
              state <= shl_pkg::ST_SEND;
            end else if (nib) begin
              sum <= sum + full_byte;
              idx <= idx + 8'h01;
              if (idx == 8'h00) begin
                len <= full_byte;
              end else if (idx == 8'h01) begin
                addr[15:8] <= full_byte;
              end else if (idx == 8'h02) begin
                addr[7:0] <= full_byte;
              end else if (idx == 8'h03) begin
                rec_type <= full_byte;
              end else if (idx - 8'h04 < len && bidx < shl_pkg::MAX_REC) begin
                buf_mem[bidx[4:0]] <= full_byte;
                bidx <= bidx + 8'h01;
              end
              if (idx >= 8'h04 && idx - 8'h04 == len) begin
                slen <= 5'h01;
                pidx <= 8'h00;
                pend <= len;
                if (8'(sum + full_byte) != 8'h00 || len > shl_pkg::MAX_REC ||
                    rec_type > shl_pkg::REC_EOF) begin
                  src <= shl_pkg::SRC_NACK;
                  state <= shl_pkg::ST_SEND;
                end else begin
                  src <= shl_pkg::SRC_ACK;
                  state <= (rec_type == shl_pkg::REC_DATA) ? shl_pkg::ST_PROG :
                           shl_pkg::ST_SEND;
                end
              end
            end
          end
        end
        shl_pkg::ST_RUNHEX: begin
          if (pop) begin
            slen <= 5'h01;
            if (!hv[4]) begin
              src <= shl_pkg::SRC_NACK;
              state <= shl_pkg::ST_SEND;
            end else begin
              addr <= {addr[11:0], hv[3:0]};
              idx <= idx + 8'h01;
              if (idx == 8'h03) begin
                run_o.go <= 1'b1;
                run_o.addr <= {addr[11:0], hv[3:0]};
                src <= shl_pkg::SRC_ACK;
                state <= shl_pkg::ST_SEND;
              end
            end
          end
        end
        shl_pkg::ST_NEWRST: begin
          if (pop) begin
            idx <= idx + 8'h01;
            sum <= sum + f_data;
            if (f_data == shl_pkg::CH_BANG) begin
              idx <= 8'h00;
              sum <= 8'h00;
            end else if ((idx == 8'h00 && f_data != shl_pkg::CH_Z) ||
                (idx == 8'h01 && f_data != 8'h00)) begin
              state <= shl_pkg::ST_HUNT;
            end else if (idx == 8'h02) begin
              tx_sum <= 8'h00;
              src <= shl_pkg::SRC_NEW_ID;
              slen <= shl_pkg::NEW_ID_LEN;
              state <= (8'(sum + f_data) == 8'h00) ? shl_pkg::ST_SEND :
                       shl_pkg::ST_HUNT;
            end
          end
        end
        shl_pkg::ST_PKT1: begin
          if (pop) begin
            state <= (f_data == shl_pkg::PKT_ID1) ? shl_pkg::ST_PKT : shl_pkg::ST_HUNT;
          end
        end
        shl_pkg::ST_PKT: begin
          if (pop) begin
            idx <= idx + 8'h01;
            sum <= sum + f_data;
            slen <= 5'h01;
            src <= shl_pkg::SRC_NACK;
            if (idx == 8'h00) begin
              len <= f_data;
              if (f_data == 8'h00 || f_data > shl_pkg::MAX_PKT) begin
                state <= shl_pkg::ST_SEND;
              end
            end else if (idx <= len) begin
              buf_mem[bidx[4:0]] <= f_data;
              bidx <= bidx + 8'h01;
            end else begin
              state <= shl_pkg::ST_SEND;
              if (8'(sum + f_data) == 8'h00) begin
                src <= shl_pkg::SRC_ACK;
                if (buf_mem[0] == shl_pkg::CMD_RUN && len >= 8'h04) begin
                  run_o.go <= 1'b1;
                  run_o.addr <= {buf_mem[2], buf_mem[3]};
                end else if (buf_mem[0] == shl_pkg::CMD_WRITE && len >= 8'h05) begin
                  addr <= {buf_mem[2], buf_mem[3]};
                  pidx <= 8'h04;
                  pend <= len;
                  state <= shl_pkg::ST_PROG;
                end else if (buf_mem[0] == shl_pkg::CMD_ERASE &&
                             buf_mem[1] == shl_pkg::ERASE_ALL) begin
                  erase_code_o <= 1'b1;
                  erase_data_o <= 1'b1;
                end else if (buf_mem[0] == shl_pkg::CMD_ERASE &&
                             buf_mem[1] == shl_pkg::ERASE_CODE) begin
                  erase_code_o <= 1'b1;
                end else begin
                  src <= shl_pkg::SRC_NACK;
                end
              end
            end
          end
        end
        shl_pkg::ST_PROG: begin
          if (pidx == pend) begin
            state <= shl_pkg::ST_SEND;
          end else begin
            mem_wr_o.we <= 1'b1;
            mem_wr_o.addr <= addr;
            mem_wr_o.data <= buf_mem[pidx[4:0]];
            addr <= addr + 16'h0001;
            pidx <= pidx + 8'h01;
          end
        end
        shl_pkg::ST_SEND: begin
          if (sidx == slen) begin
            state <= shl_pkg::ST_HUNT;
          end else if (!tx_busy && !tx_go) begin
            tx_go <= 1'b1;
            sidx <= sidx + 5'h01;
            case (src)
              shl_pkg::SRC_ACK: tx_byte <= shl_pkg::ACK;
              shl_pkg::SRC_NACK: tx_byte <= shl_pkg::NACK;
              shl_pkg::SRC_OLD_ID: tx_byte <= shl_pkg::OLD_ID[8 * (10 - sidx) +: 8];
              default: begin
                if (sidx == shl_pkg::NEW_ID_LEN - 5'h01) begin
                  tx_byte <= 8'h00 - tx_sum;
                end else begin
                  tx_byte <= shl_pkg::NEW_ID[8 * (23 - sidx) +: 8];
                  tx_sum <= tx_sum + shl_pkg::NEW_ID[8 * (23 - sidx) +: 8];
                end
              end
            endcase
          end
        end
        default: state <= shl_pkg::ST_HUNT;
      endcase
    end
  end
endmodule : shl_loader

//--- shl_loader_props.sv
`timescale 1ns/1ns
// ----------------------------------------
// loader port checker
// ----------------------------------------
module shl_loader_chk #(
  parameter logic [10:0] BIT_CYCLES = shl_pkg::BIT_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic new_gen_i,
  input wire logic uart_rx_i,
  input wire logic uart_tx_o,
  input wire shl_pkg::shl_mem_wr_type mem_wr_o,
  input wire logic erase_code_o,
  input wire logic erase_data_o,
  input wire shl_pkg::shl_run_type run_o,
  input wire logic overrun_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  // ----------------------------------------
  // low run counter on the reply line
  // ----------------------------------------
  localparam int LOW_MAX = 9 * (int'(BIT_CYCLES) + 1);
  logic [13:0] low_cnt;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || uart_tx_o) begin
      low_cnt <= 14'h0000;
    end else if (low_cnt != 14'h3FFF) begin
      low_cnt <= low_cnt + 14'h0001;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_frame_stop_bit: assert property (low_cnt <= 14'(LOW_MAX))
    else $error("reply line low past start and data bits");
  chk_tx_idle_reset: assert property ($fell(reset_i) |-> uart_tx_o)
    else $error("reply line not idle out of reset");
  chk_old_entry_erase: assert property (
    $fell(reset_i) && !new_gen_i |-> ##[1:3] (erase_code_o && erase_data_o && uart_tx_o))
    else $error("entry erase missing or after reply");
  chk_new_entry_silent: assert property (
    $fell(reset_i) && new_gen_i |-> (uart_tx_o && !erase_code_o)[*8])
    else $error("packet mode not silent at entry");
  chk_erase_data_pair: assert property (erase_data_o |-> erase_code_o)
    else $error("data erase without code erase");
  chk_erase_one_cycle: assert property (erase_code_o |=> !erase_code_o)
    else $error("erase pulse too long");
  chk_write_consec_addr: assert property (
    mem_wr_o.we && $past(mem_wr_o.we) |-> mem_wr_o.addr == $past(mem_wr_o.addr) + 16'h0001)
    else $error("write burst address not consecutive");
  chk_run_addr_hold: assert property (
    run_o.go |=> !run_o.go && run_o.addr == $past(run_o.addr))
    else $error("start pulse long or address moved");
  cover property (mem_wr_o.we);
  cover property (run_o.go);
  cover property (erase_code_o && !erase_data_o);
endmodule : shl_loader_chk

bind shl_loader shl_loader_chk #(.BIT_CYCLES(BIT_CYCLES)) chk_u (
  .sys_clk_i(sys_clk_i),
  .reset_i(reset_i),
  .new_gen_i(new_gen_i),
  .uart_rx_i(uart_rx_i),
  .uart_tx_o(uart_tx_o),
  .mem_wr_o(mem_wr_o),
  .erase_code_o(erase_code_o),
  .erase_data_o(erase_data_o),
  .run_o(run_o),
  .overrun_o(overrun_o)
);

//--- shl_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// host serial model
// ----------------------------------------
module shl_host_model #(
  parameter int BIT = shl_pkg::REF_CLK_HZ / shl_pkg::REF_BAUD
) (
  input wire logic sys_clk_i,
  input wire logic line_i,
  output logic line_o
);
  logic [7:0] rx_q[$];
  logic [7:0] rx_b;
  initial begin
    line_o = 1'b1;
  end
  // start, eight data bits lsb first, stop
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk_i);
      line_o = f[i];
      repeat (BIT - 1) @(negedge sys_clk_i);
    end
  endtask : send_byte
  // mid-bit sampling, frame dropped without stop bit
  always begin
    @(negedge line_i);
    repeat (BIT / 2) @(posedge sys_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge sys_clk_i);
      rx_b[i] = line_i;
    end
    repeat (BIT) @(posedge sys_clk_i);
    if (line_i === 1'b1) begin
      rx_q.push_back(rx_b);
    end
  end
endmodule : shl_host_model

//--- tb_shl_loader.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("FAIL %0t got %0h want %0h", $time, (a), (b)); end end
module tb_shl_loader;
  localparam int BIT = 16;
  logic sys_clk_i;
  logic reset_i;
  logic new_gen_i;
  logic uart_rx_i;
  logic uart_tx_o;
  shl_pkg::shl_mem_wr_type mem_wr_o;
  logic erase_code_o;
  logic erase_data_o;
  shl_pkg::shl_run_type run_o;
  logic overrun_o;
  logic [7:0] b, s;
  logic [15:0] run_addr;
  logic [23:0] wr_q[$];
  int err_count, n_checks, ec_n, ed_n, go_n;
  shl_loader #(.BIT_CYCLES(11'(BIT - 1)), .HALF_CYCLES(11'(BIT / 2 - 1))) dut_u (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .new_gen_i(new_gen_i),
    .uart_rx_i(uart_rx_i), .uart_tx_o(uart_tx_o), .mem_wr_o(mem_wr_o),
    .erase_code_o(erase_code_o), .erase_data_o(erase_data_o), .run_o(run_o),
    .overrun_o(overrun_o));
  shl_host_model #(.BIT(BIT)) host_u (.sys_clk_i(sys_clk_i), .line_i(uart_tx_o),
    .line_o(uart_rx_i));
  initial sys_clk_i = 1'b0;
  always #50 sys_clk_i = ~sys_clk_i;
  // ----------------------------------------
  // output monitor
  // ----------------------------------------
  always @(negedge sys_clk_i) begin
    if (mem_wr_o.we === 1'b1) wr_q.push_back({mem_wr_o.addr, mem_wr_o.data});
    if (erase_code_o === 1'b1) ec_n++;
    if (erase_data_o === 1'b1) ed_n++;
    if (run_o.go === 1'b1) begin
      go_n++;
      run_addr = run_o.addr;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic do_reset(input logic g);
    @(negedge sys_clk_i);
    reset_i = 1'b1;
    new_gen_i = g;
    repeat (16) @(negedge sys_clk_i);
    {ec_n, ed_n, go_n} = '0;
    wr_q.delete();
    host_u.rx_q.delete();
    reset_i = 1'b0;
  endtask : do_reset
  task automatic send_str(input string t);
    for (int i = 0; i < t.len(); i++) host_u.send_byte(t[i]);
  endtask : send_str
  task automatic send_q(input logic [7:0] q[$]);
    foreach (q[i]) host_u.send_byte(q[i]);
  endtask : send_q
  task automatic expect_byte(input logic [7:0] e);
    int t;
    t = 0;
    while (host_u.rx_q.size() == 0 && t < 40 * BIT) begin
      @(negedge sys_clk_i);
      t++;
    end
    b = (host_u.rx_q.size() > 0) ? host_u.rx_q.pop_front() : 8'hXX;
    `CHK(b, e)
  endtask : expect_byte
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_fifo_full;
    do_reset(1'b1);
    send_q('{8'h21, 8'h5A, 8'h00, 8'hA6});
    send_q('{8'h07, 8'h0E, 8'h02, 8'h45, 8'h43, 8'h76});
    send_q('{8'h07, 8'h0E, 8'h06, 8'h57, 8'h00, 8'h12, 8'h34, 8'hAB, 8'hCD, 8'hE5});
    `CHK(overrun_o, 1'b0)
    `CHK(wr_q.size(), 0)
    for (int i = 0; i < 24; i++) expect_byte(shl_pkg::NEW_ID[191 - 8 * i -: 8]);
    expect_byte(8'h00 - s);
    expect_byte(8'h06);
    `CHK(ec_n, 1)
    `CHK(ed_n, 0)
    expect_byte(8'h06);
    `CHK(wr_q.size(), 2)
    `CHK(wr_q[0], 24'h1234AB)
    `CHK(wr_q[1], 24'h1235CD)
    `CHK(overrun_o, 1'b0)
    send_q('{8'h21, 8'h5A, 8'h00, 8'hA6});
    repeat (17) host_u.send_byte(8'h00);
    `CHK(overrun_o, 1'b1)
    $display("done fifo full");
  endtask : test_fifo_full
  task automatic test_old_record;
    do_reset(1'b0);
    send_str("x:0200100055AAEF");
    `CHK(ec_n, 1)
    `CHK(ed_n, 1)
    for (int i = 0; i < 11; i++) expect_byte(shl_pkg::OLD_ID[87 - 8 * i -: 8]);
    expect_byte(8'h06);
    `CHK(wr_q.size(), 2)
    `CHK(wr_q[0], 24'h001055)
    `CHK(wr_q[1], 24'h0011AA)
    $display("done old record");
  endtask : test_old_record
  task automatic test_old_fail;
    wr_q.delete();
    send_str(":0100200011CF");
    expect_byte(8'h15);
    send_str("Z:00000001FF");
    expect_byte(8'h06);
    `CHK(wr_q.size(), 0)
    $display("done old fail");
  endtask : test_old_fail
  task automatic test_old_run;
    send_str(";FF00");
    expect_byte(8'h06);
    `CHK(go_n, 1)
    `CHK(run_addr, 16'hFF00)
    $display("done old run");
  endtask : test_old_run
  task automatic test_new_reset;
    do_reset(1'b1);
    host_u.send_byte(8'h21);
    repeat (40 * BIT) @(negedge sys_clk_i);
    `CHK(host_u.rx_q.size(), 0)
    send_q('{8'h21, 8'h5A, 8'h00, 8'hA6});
    s = 8'h00;
    for (int i = 0; i < 24; i++) begin
      expect_byte(shl_pkg::NEW_ID[191 - 8 * i -: 8]);
      s = s + shl_pkg::NEW_ID[191 - 8 * i -: 8];
    end
    expect_byte(8'h00 - s);
    `CHK(ec_n, 0)
    $display("done new reset");
  endtask : test_new_reset
  task automatic test_new_erase;
    send_q('{8'h07, 8'h0E, 8'h02, 8'h45, 8'h43, 8'h76});
    expect_byte(8'h06);
    `CHK(ec_n, 1)
    `CHK(ed_n, 0)
    send_q('{8'h07, 8'h0E, 8'h02, 8'h45, 8'h41, 8'h78});
    expect_byte(8'h06);
    `CHK(ec_n, 2)
    `CHK(ed_n, 1)
    $display("done new erase");
  endtask : test_new_erase
  task automatic test_new_write_run;
    send_q('{8'h07, 8'h0E, 8'h06, 8'h57, 8'h00, 8'h12, 8'h34, 8'hAB, 8'hCD, 8'hE5});
    expect_byte(8'h06);
    `CHK(wr_q.size(), 2)
    `CHK(wr_q[0], 24'h1234AB)
    `CHK(wr_q[1], 24'h1235CD)
    send_q('{8'h07, 8'h0E, 8'h04, 8'h55, 8'h00, 8'h0F, 8'h00, 8'h98});
    expect_byte(8'h06);
    `CHK(run_addr, 16'h0F00)
    `CHK(overrun_o, 1'b0)
    $display("done new write run");
  endtask : test_new_write_run
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    reset_i = 1'b1;
    new_gen_i = 1'b0;
    {err_count, n_checks, ec_n, ed_n, go_n} = '0;
    run_addr = 16'h0000;
    test_old_record();
    test_old_fail();
    test_old_run();
    test_new_reset();
    test_new_erase();
    test_new_write_run();
    test_fifo_full();
    complete_run();
  end
  initial begin
    #6000000;
    err_count++;
    complete_run();
  end
endmodule : tb_shl_loader
